// [include/adc_watch_regs.svh]
// constants of the converter control block
`ifndef ADC_WATCH_REGS_SVH
`define ADC_WATCH_REGS_SVH
`define CONV_CLK_CYCLES 14
`define RES_W 10
`define NUM_CH 16
`define CH_W 4
`define BUF_DEPTH_DEF 10
`define PRESC_DEF 1
`define SEL_PIN 2'h0
`define SEL_TIMER 2'h1
`define CNT_W 16
`endif

// [include/adc_watch_pkg.sv]
// types shared by the converter control block
package adc_watch_pkg;
   typedef struct packed {
      logic [9:0] high;
      logic [9:0] low;
   } threshold_type;
   typedef struct packed {
      logic repeat_bit;
      logic scan_bit;
      logic buffering_bit;
   } mode_type;
   typedef enum logic [1:0] {
      ST_OFF    = 2'h0,
      ST_SETTLE = 2'h1,
      ST_IDLE   = 2'h3,
      ST_CONV   = 2'h2
   } conv_state_type;
endpackage

// [rtl/pin_sync3.sv]
// three-stage synchroniser with rising edge detect for a pin
`timescale 1ns/1ps
module pin_sync3 (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // pin side
   input  wire logic pin_in,
   // synchronous side
   output logic      level_q,
   output logic      rise_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         level_q <= 1'b0;
         rise_q  <= 1'b0;
      end else begin
         rise_q <= (s2_q == s3_q) && s3_q && !level_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule // pin_sync3

// [rtl/adc_watchdog_trigger_ctrl.sv]
// converter sequencing, watchdog, overrun and trigger control
`timescale 1ns/1ps
`include "adc_watch_regs.svh"
module adc_watchdog_trigger_ctrl #(
   parameter int PRESC     = `PRESC_DEF,
   parameter int BUF_DEPTH = `BUF_DEPTH_DEF
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   // software control
   input  wire logic                        power_on_write,
   input  wire logic                        power_off_write,
   input  wire adc_watch_pkg::mode_type     mode,
   input  wire logic                        channel_write,
   input  wire logic [`CH_W-1:0]            channel_wdata,
   input  wire logic                        ext_trigger_enable,
   input  wire logic [1:0]                  trigger_source_select,
   input  wire logic                        conversion_done_irq_enable,
   input  wire logic                        watchdog_irq_enable,
   input  wire adc_watch_pkg::threshold_type thresholds,
   input  wire logic [`NUM_CH-1:0]          per_channel_watch_enable,
   input  wire logic                        done_clear,
   input  wire logic                        watchdog_flag_clear,
   input  wire logic [`NUM_CH-1:0]          watch_status_clear,
   input  wire logic                        halt_request,
   // buffer read port
   input  wire logic                        buf_read,
   input  wire logic [`CH_W-1:0]            buf_read_idx,
   output logic [`RES_W-1:0]                buf_read_data_q,
   // trigger sources
   input  wire logic                        external_trigger_pin,
   input  wire logic                        timer_trigger_output,
   // analog core
   input  wire logic [`RES_W-1:0]           analog_sample,
   output logic                             analog_power,
   output logic                             converting,
   // status
   output logic [`CH_W-1:0]                 channel_field,
   output logic [`RES_W-1:0]                result_q,
   output logic                             done_flag_q,
   output logic                             overrun_flag_q,
   output logic                             watchdog_flag_q,
   output logic [`NUM_CH-1:0]               per_channel_watch_status_q,
   output logic                             converter_irq
);
   import adc_watch_pkg::*;

   // settling lasts exactly one conversion time
   localparam int CONV_TICKS = `CONV_CLK_CYCLES * PRESC;
   localparam logic [`CNT_W-1:0] LAST_TICK = `CNT_W'(CONV_TICKS - 1);
   localparam logic [`CH_W-1:0] BUF_LAST = `CH_W'(BUF_DEPTH - 1);

   conv_state_type              state_q;
   logic [`CNT_W-1:0]           cnt_q;
   logic [`CH_W-1:0]            idx_q;
   logic [`CH_W-1:0]            chan_sel_q;
   logic                        ext_en_q;
   logic                        wd_irq_q;
   logic [`NUM_CH-1:0]          unread_q;
   logic [`RES_W-1:0]           buf_q [`NUM_CH];
   logic                        pin_level;
   logic                        pin_rise;
   logic                        src_level;
   logic                        trig_evt;
   logic                        en_rise;
   logic                        power_down;
   logic                        start_req;
   logic                        conv_end;
   logic                        seq_mode;
   logic                        seq_last;
   logic                        out_of_window;
   logic                        wd_hit;
   logic                        stop_now;
   logic                        seq_done;
   logic [`NUM_CH-1:0]          status_set;

   pin_sync3 u_pin_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (external_trigger_pin),
      .level_q (pin_level),
      .rise_q  (pin_rise)
   );

   // trigger source selection; unused codes never fire
   always_comb begin
      src_level = 1'b0;
      trig_evt  = 1'b0;
      case (trigger_source_select)
         `SEL_PIN: begin
            src_level = pin_level;
            trig_evt  = pin_rise;
         end
         `SEL_TIMER: begin
            src_level = timer_trigger_output;
            trig_evt  = timer_trigger_output;
         end
         default: begin
            src_level = 1'b0;
            trig_evt  = 1'b0;
         end
      endcase
      trig_evt = trig_evt && ext_trigger_enable;
   end

   assign en_rise    = ext_trigger_enable && !ext_en_q && src_level;
   assign power_down = power_off_write || halt_request;
   assign start_req  = (power_on_write && state_q != ST_OFF) || trig_evt;
   assign conv_end   = (state_q == ST_CONV) && (cnt_q == LAST_TICK);

   // scan and buffered continuous both fill the data buffer
   assign seq_mode = mode.scan_bit ||
                     (mode.repeat_bit && mode.buffering_bit);
   assign seq_last = mode.scan_bit ? (idx_q == chan_sel_q)
                                   : (idx_q == BUF_LAST);
   assign seq_done = conv_end && (!seq_mode || seq_last);

   assign out_of_window = (analog_sample < thresholds.low) ||
                          (analog_sample > thresholds.high);
   // outside sequences no per-channel enable is consulted
   assign wd_hit = conv_end && out_of_window &&
                   (!seq_mode || per_channel_watch_enable[idx_q]);
   assign stop_now = seq_mode && wd_hit && watchdog_irq_enable &&
                     conversion_done_irq_enable;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_en_q <= 1'b0;
      end else begin
         ext_en_q <= ext_trigger_enable;
      end
   end

   // sequencer: power, settling, conversion timing and stepping
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_OFF;
         cnt_q   <= '0;
         idx_q   <= '0;
      end else if (power_down) begin
         state_q <= ST_OFF;
         cnt_q   <= '0;
         idx_q   <= '0;
      end else begin
         case (state_q)
            ST_OFF: begin
               cnt_q <= '0;
               idx_q <= '0;
               if (power_on_write || en_rise) begin
                  state_q <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // an early start is honoured but its result is inaccurate
               if (start_req) begin
                  state_q <= ST_CONV;
                  cnt_q   <= '0;
               end else if (cnt_q == LAST_TICK) begin
                  state_q <= ST_IDLE;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_IDLE: begin
               cnt_q <= '0;
               if (start_req) begin
                  state_q <= ST_CONV;
                  idx_q   <= '0;
               end
            end
            ST_CONV: begin
               if (!conv_end) begin
                  cnt_q <= cnt_q + 1'b1;
               end else begin
                  cnt_q <= '0;
                  if (stop_now) begin
                     state_q <= ST_IDLE;
                  end else if (seq_mode && !seq_last) begin
                     idx_q <= idx_q + 1'b1;
                  end else if (mode.repeat_bit) begin
                     idx_q <= '0;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_q <= ST_OFF;
               cnt_q   <= '0;
               idx_q   <= '0;
            end
         endcase
      end
   end

   // last channel of the scan, reloaded by each software write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chan_sel_q <= '0;
      end else if (channel_write) begin
         chan_sel_q <= channel_wdata;
      end
   end

   assign channel_field = (mode.scan_bit && state_q == ST_CONV) ?
                          idx_q : chan_sel_q;
   assign analog_power  = (state_q != ST_OFF);
   assign converting    = (state_q == ST_CONV);

   // result register and data buffer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         result_q <= '0;
      end else if (conv_end) begin
         result_q <= analog_sample;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (conv_end && seq_mode) begin
         buf_q[idx_q] <= analog_sample;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_read_data_q <= '0;
      end else if (buf_read) begin
         buf_read_data_q <= buf_q[buf_read_idx];
      end
   end

   // per-entry unread marks and watchdog status; a new value beats a read
   for (genvar g = 0; g < `NUM_CH; g++) begin : g_entry
      logic wr_here;
      assign wr_here = conv_end && seq_mode && (idx_q == `CH_W'(g));
      assign status_set[g] = wr_here && wd_hit;
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            unread_q[g] <= 1'b0;
         end else if (wr_here) begin
            unread_q[g] <= 1'b1;
         end else if (buf_read && buf_read_idx == `CH_W'(g)) begin
            unread_q[g] <= 1'b0;
         end
      end
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            per_channel_watch_status_q[g] <= 1'b0;
         end else if (status_set[g]) begin
            per_channel_watch_status_q[g] <= 1'b1;
         end else if (watch_status_clear[g]) begin
            per_channel_watch_status_q[g] <= 1'b0;
         end
      end
   end

   // overrun: hardware set beats the clear from a start write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overrun_flag_q <= 1'b0;
      end else if (conv_end && seq_mode && unread_q[idx_q]) begin
         overrun_flag_q <= 1'b1;
      end else if (power_on_write) begin
         overrun_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done_flag_q <= 1'b0;
      end else if (seq_done && !stop_now) begin
         done_flag_q <= 1'b1;
      end else if (done_clear) begin
         done_flag_q <= 1'b0;
      end
   end

   // global flag follows any status bit, so clear status bits first
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         watchdog_flag_q <= 1'b0;
      end else if (wd_hit || (|per_channel_watch_status_q)) begin
         watchdog_flag_q <= 1'b1;
      end else if (watchdog_flag_clear) begin
         watchdog_flag_q <= 1'b0;
      end
   end

   // watchdog request waits for the sequence end unless stopping
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wd_irq_q <= 1'b0;
      end else if (watchdog_irq_enable &&
                   ((wd_hit && (!seq_mode || stop_now)) ||
                    (seq_done && (wd_hit ||
                     (|per_channel_watch_status_q))))) begin
         wd_irq_q <= 1'b1;
      end else if (watchdog_flag_clear) begin
         wd_irq_q <= 1'b0;
      end
   end

   assign converter_irq = wd_irq_q ||
                          (done_flag_q && conversion_done_irq_enable);

   // helper counter for the length of one conversion
   logic [`CNT_W-1:0] age_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         age_q <= '0;
      end else if (state_q != ST_CONV || conv_end) begin
         age_q <= '0;
      end else begin
         age_q <= age_q + 1'b1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_ovr_cause;
      conv_end && seq_mode && unread_q[idx_q];
   endsequence

   AST_OVR_SET: assert property (s_ovr_cause |=> overrun_flag_q)
      else $error("overrun not set on rewrite");
   AST_OVR_CLR: assert property (
      power_on_write && !(conv_end && seq_mode && unread_q[idx_q])
      |=> !overrun_flag_q)
      else $error("start write did not clear overrun");
   AST_WD_PLAIN: assert property (
      conv_end && !seq_mode && out_of_window |=> watchdog_flag_q)
      else $error("watchdog missed in plain mode");
   AST_WD_IRQ_GATE: assert property (
      $rose(wd_irq_q) |-> $past(watchdog_irq_enable))
      else $error("watchdog irq without enable");
   AST_STATUS_MASK: assert property (
      conv_end && seq_mode && !per_channel_watch_enable[idx_q] &&
      !per_channel_watch_status_q[idx_q]
      |=> !per_channel_watch_status_q[$past(idx_q)])
      else $error("status set on disabled channel");
   AST_GLOBAL: assert property (
      |per_channel_watch_status_q |=> watchdog_flag_q)
      else $error("global flag not following status");
   AST_STOP: assert property (
      stop_now && !power_down |=> state_q == ST_IDLE ##0 wd_irq_q)
      else $error("scan not stopped on watchdog");
   AST_TRIG: assert property (
      trig_evt && state_q == ST_IDLE && !power_down
      |=> state_q == ST_CONV)
      else $error("trigger did not start conversion");
   AST_ARM: assert property (
      en_rise && state_q == ST_OFF && !power_down
      |=> state_q == ST_SETTLE)
      else $error("high source did not power on");
   AST_CONV_LEN: assert property (
      conv_end |-> age_q == LAST_TICK ##1 done_flag_q || seq_mode)
      else $error("conversion length wrong");
   AST_HALT: assert property (halt_request |=> state_q == ST_OFF)
      else $error("halt did not switch converter off");
endmodule // adc_watchdog_trigger_ctrl

// [sim/analog_model.sv]
// analog core model facing the converter control block
`timescale 1ns/1ps
module analog_model (
   // clock
   input  wire logic             sys_clk,
   // converter control side
   input  wire logic             analog_power,
   input  wire logic             converting,
   input  wire logic [3:0]       channel_field,
   // level applied to each analog input
   input  wire logic [15:0][9:0] levels,
   output logic      [9:0]       analog_sample
);
   logic [9:0] last_q = 10'h000;
   // idle or unpowered core toggles so a stale value never looks valid
   always_comb begin
      if (analog_power && converting) begin
         analog_sample = levels[channel_field];
      end else begin
         analog_sample = ~last_q;
      end
   end
   always_ff @(posedge sys_clk) begin
      last_q <= analog_sample;
   end
endmodule // analog_model

// [sim/testbench.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
module testbench;
   import adc_watch_pkg::*;
   localparam int BD = 8;
   logic sys_clk, rst, power_on_write, power_off_write, channel_write;
   logic ext_trigger_enable, conversion_done_irq_enable, watchdog_irq_enable;
   logic done_clear, watchdog_flag_clear, halt_request, buf_read;
   logic external_trigger_pin, timer_trigger_output, analog_power;
   logic converting, done_flag_q, overrun_flag_q, watchdog_flag_q;
   logic converter_irq;
   mode_type      mode;
   threshold_type thresholds;
   logic [3:0]    channel_wdata, buf_read_idx, channel_field;
   logic [1:0]    trigger_source_select;
   logic [15:0]   per_channel_watch_enable, watch_status_clear, stat;
   logic [15:0]   per_channel_watch_status_q;
   logic [9:0]    buf_read_data_q, analog_sample, result_q;
   logic [15:0][9:0] levels;
   logic [31:0]   lfsr;
   int            n_errors, checks, cyc, conv_n;

   adc_watchdog_trigger_ctrl #(.PRESC(1), .BUF_DEPTH(BD)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .power_on_write(power_on_write),
      .power_off_write(power_off_write), .mode(mode),
      .channel_write(channel_write), .channel_wdata(channel_wdata),
      .ext_trigger_enable(ext_trigger_enable),
      .trigger_source_select(trigger_source_select),
      .conversion_done_irq_enable(conversion_done_irq_enable),
      .watchdog_irq_enable(watchdog_irq_enable), .thresholds(thresholds),
      .per_channel_watch_enable(per_channel_watch_enable),
      .done_clear(done_clear), .watchdog_flag_clear(watchdog_flag_clear),
      .watch_status_clear(watch_status_clear), .halt_request(halt_request),
      .buf_read(buf_read), .buf_read_idx(buf_read_idx),
      .buf_read_data_q(buf_read_data_q),
      .external_trigger_pin(external_trigger_pin),
      .timer_trigger_output(timer_trigger_output),
      .analog_sample(analog_sample), .analog_power(analog_power),
      .converting(converting), .channel_field(channel_field),
      .result_q(result_q), .done_flag_q(done_flag_q),
      .overrun_flag_q(overrun_flag_q), .watchdog_flag_q(watchdog_flag_q),
      .per_channel_watch_status_q(per_channel_watch_status_q),
      .converter_irq(converter_irq));

   analog_model u_core (
      .sys_clk(sys_clk), .analog_power(analog_power),
      .converting(converting), .channel_field(channel_field),
      .levels(levels), .analog_sample(analog_sample));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   function automatic logic [9:0] rnd10();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[9:0];
   endfunction
   // window is inclusive: only strictly outside trips the watchdog
   function automatic logic out_win(input logic [9:0] v);
      return (v < thresholds.low) || (v > thresholds.high);
   endfunction

   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // done is cleared together with the start so each wait sees a fresh flag
   task automatic start();
      @(posedge sys_clk);
      power_on_write <= 1'b1;
      done_clear     <= 1'b1;
      @(posedge sys_clk);
      power_on_write <= 1'b0;
      done_clear     <= 1'b0;
      #1;
   endtask
   task automatic wait_done();
      cyc    = 0;
      conv_n = 0;
      // count the cycle in hand before stepping, so the first one counts
      while (done_flag_q !== 1'b1 && cyc < 3000) begin
         if (converting === 1'b1) conv_n++;
         tick(1);
         cyc++;
      end
      chk("done flag", done_flag_q, 1'b1);
   endtask
   task automatic wait_conv(input logic exp);
      cyc = 0;
      while (converting !== 1'b1 && cyc < 20) begin
         tick(1);
         cyc++;
      end
      chk("trigger start", converting, exp);
   endtask
   task automatic clear_watch();
      @(posedge sys_clk);
      watch_status_clear  <= 16'hffff;
      @(posedge sys_clk);
      watch_status_clear  <= 16'h0000;
      watchdog_flag_clear <= 1'b1;
      @(posedge sys_clk);
      watchdog_flag_clear <= 1'b0;
      #1;
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #200us;
      n_errors++;
      $display("[ERR] watchdog expired");
      finish_test();
   end

   initial begin
      logic [9:0] corner [4];
      corner = '{10'h0ff, 10'h100, 10'h300, 10'h301};
      {power_on_write, power_off_write, channel_write, buf_read} = 4'h0;
      {ext_trigger_enable, conversion_done_irq_enable} = 2'h0;
      {watchdog_irq_enable, done_clear, watchdog_flag_clear} = 3'h0;
      {halt_request, external_trigger_pin, timer_trigger_output} = 3'h0;
      {channel_wdata, buf_read_idx, trigger_source_select} = 10'h000;
      per_channel_watch_enable = 16'h0000;
      watch_status_clear = 16'h0000;
      mode = '0;
      thresholds = '{10'h300, 10'h100};
      levels = '0;
      lfsr = 32'ha06f;
      n_errors = 0;
      checks = 0;
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      tick(1);
      chk("power after reset", analog_power, 1'b0);
      chk("flags after reset", {done_flag_q, overrun_flag_q,
          watchdog_flag_q}, 3'h0);
      $display("test reset finished");
      // single mode; settle of one conversion time before the real start
      @(posedge sys_clk);
      channel_wdata <= 4'h5;
      channel_write <= 1'b1;
      power_on_write <= 1'b1;
      @(posedge sys_clk);
      {channel_write, power_on_write} <= 2'h0;
      tick(20);
      for (int i = 0; i < 12; i++) begin
         levels[5] = (i < 4) ? corner[i] : rnd10();
         watchdog_irq_enable <= i[0];
         conversion_done_irq_enable <= i[1];
         start();
         wait_done();
         chk("conversion cycles", conv_n, 16'd14);
         chk("result", result_q, levels[5]);
         chk("watch flag", watchdog_flag_q, out_win(levels[5]));
         chk("irq", converter_irq, (out_win(levels[5]) & i[0]) | i[1]);
         clear_watch();
      end
      $display("test single finished");
      // single scan over channels 0..3, watchdog on channels 0 and 2
      conversion_done_irq_enable <= 1'b0;
      watchdog_irq_enable <= 1'b1;
      per_channel_watch_enable <= 16'h0005;
      mode <= '{1'b0, 1'b1, 1'b0};
      channel_wdata <= 4'h3;
      channel_write <= 1'b1;
      tick(1);
      channel_write <= 1'b0;
      for (int k = 0; k < 4; k++) levels[k] = rnd10();
      levels[0] = 10'h3ff;
      levels[1] = 10'h000;
      stat = 16'h0000;
      for (int k = 0; k < 4; k++) stat[k] = (k % 2 == 0) && out_win(levels[k]);
      start();
      wait_done();
      chk("scan last channel", channel_field, 4'h3);
      chk("channel status", per_channel_watch_status_q, stat);
      chk("scan watch flag", watchdog_flag_q, 1'b1);
      chk("scan irq", converter_irq, 1'b1);
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         buf_read <= 1'b1;
         buf_read_idx <= k[3:0];
         @(posedge sys_clk);
         buf_read <= 1'b0;
         #1;
         chk("buffer entry", buf_read_data_q, levels[k]);
      end
      clear_watch();
      chk("status cleared", per_channel_watch_status_q, 16'h0000);
      start();
      wait_done();
      chk("overrun after reads", overrun_flag_q, 1'b0);
      start();
      wait_done();
      chk("overrun unread", overrun_flag_q, 1'b1);
      start();
      chk("overrun cleared", overrun_flag_q, 1'b0);
      wait_done();
      // both enables: stop at the first out-of-window channel
      clear_watch();
      conversion_done_irq_enable <= 1'b1;
      start();
      cyc = 0;
      while (converter_irq !== 1'b1 && cyc < 200) begin
         tick(1);
         cyc++;
      end
      tick(3);
      chk("scan stopped", {converting, done_flag_q}, 2'h0);
      $display("test scan finished");
      // buffered continuous on channel 3, watch on entries 0 and 7
      conversion_done_irq_enable <= 1'b0;
      per_channel_watch_enable <= 16'h0081;
      mode <= '{1'b1, 1'b0, 1'b1};
      levels[3] = 10'h3ff;
      clear_watch();
      start();
      wait_done();
      chk("buffer run", conv_n, BD * 14);
      chk("entry status", per_channel_watch_status_q, 16'h0081);
      tick(3);
      chk("restarted", converting, 1'b1);
      @(posedge sys_clk);
      power_off_write <= 1'b1;
      @(posedge sys_clk);
      power_off_write <= 1'b0;
      tick(2);
      chk("powered off", analog_power, 1'b0);
      $display("test buffered finished");
      // external triggers: converter off, select source, then enable
      mode <= '0;
      clear_watch();
      start();
      @(posedge sys_clk);
      power_off_write <= 1'b1;
      trigger_source_select <= 2'h0;
      external_trigger_pin <= 1'b1;
      @(posedge sys_clk);
      power_off_write <= 1'b0;
      // the pin level needs four clocks through the synchroniser
      tick(5);
      ext_trigger_enable <= 1'b1;
      tick(10);
      chk("source high powers on", analog_power, 1'b1);
      external_trigger_pin <= 1'b0;
      tick(20);
      external_trigger_pin <= 1'b1;
      wait_conv(1'b1);
      wait_done();
      chk("pin result", result_q, levels[3]);
      trigger_source_select <= 2'h1;
      // a stale done flag would end the next wait at once
      done_clear <= 1'b1;
      tick(1);
      done_clear <= 1'b0;
      tick(1);
      timer_trigger_output <= 1'b1;
      tick(1);
      timer_trigger_output <= 1'b0;
      wait_conv(1'b1);
      wait_done();
      trigger_source_select <= 2'h2;
      tick(2);
      timer_trigger_output <= 1'b1;
      tick(1);
      timer_trigger_output <= 1'b0;
      wait_conv(1'b0);
      ext_trigger_enable <= 1'b0;
      halt_request <= 1'b1;
      tick(1);
      halt_request <= 1'b0;
      tick(2);
      chk("halt powers off", analog_power, 1'b0);
      // wake-up: power on again and wait 7 us before a new conversion
      start();
      tick(1400);
      start();
      wait_done();
      chk("result after halt", result_q, levels[3]);
      $display("test trigger finished");
      finish_test();
   end
endmodule // testbench
